// file: logic/standard_timer.sv
// Standard timer: 10-bit up counter, period and compare comparators, APB registers.
//
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/1ns
`default_nettype none
`include "standard_timer_params.svh"

module standard_timer
(
    // APB clock and reset.
    input  wire logic                         pclk,
    input  wire logic                         presetn,
    // APB slave request and answer.
    input  wire standard_timer_pkg::apb_req_t apb_req,
    output var  standard_timer_pkg::apb_rsp_t apb_rsp,
    // Clock-rate strobes from logic on pclk.
    input  wire logic                         high_speed_clock,
    input  wire logic                         time_base_clock,
    // Timer pins.
    input  wire logic                         external_clock_pin,
    input  wire logic                         capture_input_pin,
    output logic                              timer_output_pin,
    output logic                              timer_output_enable,
    output logic                              complementary_output_pin,
    // Event pulses to the interrupt controller.
    output logic                              compare_event,
    output logic                              period_event
);
    import standard_timer_pkg::*;

    control_0_t  control_0;
    control_1_t  control_1;
    logic [9:0]  counter;
    logic [9:0]  compare_register;
    logic [7:0]  low_buffer;
    logic        on_prev;
    logic [1:0]  sys_prescale;
    logic [5:0]  high_prescale;
    logic        ext_s1, ext_s2, ext_s3;
    logic        cap_s1, cap_s2, cap_s3;
    logic        raw_level;

    logic        on_rise;
    logic        tick;
    logic        run_tick;
    logic [10:0] next_count;
    logic [10:0] period_target;
    logic [10:0] compare_target;
    logic        period_hit;
    logic        compare_hit;
    logic        clear_on_compare;
    logic        clear_hit;
    logic        capture_edge;
    logic        compare_like;
    logic        bus_access;
    logic        bus_setup;
    logic        addr_mapped;
    logic [7:0]  read_byte;

    // Bus phase decode; writes and read side effects land on the completing edge.
    assign bus_setup  = apb_req.psel & ~apb_req.penable;
    assign bus_access = apb_req.psel & apb_req.penable & apb_rsp.pready;
    assign on_rise    = control_0.on_off_bit & ~on_prev;
    assign compare_like = (control_1.mode_select_field == MODE_COMPARE) |
                          (control_1.mode_select_field == MODE_TIMER);

    // Address decode and read mux; low bytes return the shared buffer.
    always_comb
    begin
        addr_mapped = 1'b1;
        read_byte   = 8'h00;
        unique case (apb_req.paddr)
            `TIMER_CONTROL_0_OFFSET:   read_byte = control_0;
            `TIMER_CONTROL_1_OFFSET:   read_byte = control_1;
            `COUNTER_LOW_BYTE_OFFSET:  read_byte = low_buffer;
            `COUNTER_HIGH_BYTE_OFFSET: read_byte = {6'h00, counter[9:8]};
            `COMPARE_LOW_BYTE_OFFSET:  read_byte = low_buffer;
            `COMPARE_HIGH_BYTE_OFFSET: read_byte = {6'h00, compare_register[9:8]};
            default:                   addr_mapped = 1'b0;
        endcase
    end

    // No wait state: the answer is prepared in setup so it leaves a flip-flop.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            apb_rsp <= '0;
        end
        else
        begin
            apb_rsp.pready  <= bus_setup;
            apb_rsp.pslverr <= bus_setup & ~addr_mapped;
            if (bus_setup)
                apb_rsp.prdata <= {24'h000000, read_byte};
        end
    end

    // Control registers; 8-bit data sits in the low lane of pwdata.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            control_0 <= `TIMER_CONTROL_0_RESET;
            control_1 <= `TIMER_CONTROL_1_RESET;
        end
        else if (bus_access && apb_req.pwrite)
        begin
            if (apb_req.paddr == `TIMER_CONTROL_0_OFFSET)
                control_0 <= apb_req.pwdata[7:0];
            if (apb_req.paddr == `TIMER_CONTROL_1_OFFSET)
                control_1 <= apb_req.pwdata[7:0];
        end
    end

    // Low-byte buffer, shared by counter and compare pairs.
    // buffer fill and latch
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            low_buffer <= 8'h00;
        else if (bus_access && apb_req.pwrite &&
                 apb_req.paddr == `COMPARE_LOW_BYTE_OFFSET)
            low_buffer <= apb_req.pwdata[7:0];
        else if (bus_access && !apb_req.pwrite &&
                 apb_req.paddr == `COUNTER_HIGH_BYTE_OFFSET)
            low_buffer <= counter[7:0];
        else if (bus_access && !apb_req.pwrite &&
                 apb_req.paddr == `COMPARE_HIGH_BYTE_OFFSET)
            low_buffer <= compare_register[7:0];
    end

    // Compare register: capture wins over a simultaneous software load.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            compare_register <= `COMPARE_RESET;
        else if (capture_edge)
            compare_register <= counter;
        else if (bus_access && apb_req.pwrite &&
                 apb_req.paddr == `COMPARE_HIGH_BYTE_OFFSET)
            compare_register <= {apb_req.pwdata[1:0], low_buffer};
    end

    // Two-flop synchronisers, then a third stage for edge detection.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ext_s1 <= 1'b0;
            ext_s2 <= 1'b0;
            ext_s3 <= 1'b0;
            cap_s1 <= 1'b0;
            cap_s2 <= 1'b0;
            cap_s3 <= 1'b0;
        end
        else
        begin
            ext_s1 <= external_clock_pin;
            ext_s2 <= ext_s1;
            ext_s3 <= ext_s2;
            cap_s1 <= capture_input_pin;
            cap_s2 <= cap_s1;
            cap_s3 <= cap_s2;
        end
    end

    // Prescalers run freely, so the first divided tick after start may be short.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sys_prescale  <= 2'h0;
            high_prescale <= 6'h00;
        end
        else
        begin
            sys_prescale <= sys_prescale + 2'h1;
            if (high_speed_clock)
                high_prescale <= high_prescale + 6'h01;
        end
    end

    // Timer clock selection.
    // clock source select
    always_comb
    begin
        unique case (control_0.clock_select_field)
            CLK_SYS_4:    tick = (sys_prescale == `SYS_DIVIDE);
            CLK_SYS:      tick = 1'b1;
            CLK_HIGH_16:  tick = high_speed_clock &
                                 (high_prescale[3:0] == `HIGH_DIVIDE_16);
            CLK_HIGH_64:  tick = high_speed_clock &
                                 (high_prescale == `HIGH_DIVIDE_64);
            CLK_TBC_A:    tick = time_base_clock;
            CLK_TBC_B:    tick = time_base_clock;
            CLK_EXT_RISE: tick = ext_s2 & ~ext_s3;
            CLK_EXT_FALL: tick = ~ext_s2 & ext_s3;
        endcase
    end

    // Capture edge selection.
    // capture edge select
    always_comb
    begin
        capture_edge = 1'b0;
        if (control_1.mode_select_field == MODE_CAPTURE && control_0.on_off_bit)
        begin
            unique case (control_1.function_select_field)
                2'b00: capture_edge = cap_s2 & ~cap_s3;
                2'b01: capture_edge = ~cap_s2 & cap_s3;
                2'b10: capture_edge = cap_s2 ^ cap_s3;
                2'b11: capture_edge = 1'b0;
            endcase
        end
    end

    assign run_tick   = tick & control_0.on_off_bit & ~control_0.pause_bit & ~on_rise;
    assign next_count = {1'b0, counter} + 11'h001;

    // Match targets; a zero field means the full 1024-clock span.
    // period in 128 steps
    assign period_target  = (control_0.period_value_field == 3'h0) ? `FULL_SPAN :
                            {1'b0, control_0.period_value_field, 7'h00};
    assign compare_target = (compare_register == 10'h000) ? `FULL_SPAN :
                            {1'b0, compare_register};
    assign period_hit  = run_tick & (next_count[10:`PERIOD_STEP_SHIFT] ==
                                     period_target[10:`PERIOD_STEP_SHIFT]) &
                         (next_count[`PERIOD_STEP_SHIFT-1:0] == 7'h00);
    assign compare_hit = run_tick & (next_count == compare_target);

    assign clear_on_compare = compare_like ? control_1.counter_clear_select_bit :
                              (control_1.mode_select_field == MODE_PWM) &
                              control_1.period_duty_swap_bit;
    assign clear_hit = clear_on_compare ? compare_hit : period_hit;

    // The counter; software only reaches it through the on bit.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            counter <= 10'h000;
            on_prev <= 1'b0;
        end
        else
        begin
            on_prev <= control_0.on_off_bit;
            if (on_rise)
                counter <= 10'h000;
            else if (clear_hit)
                counter <= 10'h000;
            else if (run_tick)
                counter <= next_count[9:0];
        end
    end

    // Event pulses; period events are withheld while counter_clear_select_bit selects compare clearing in compare or timer mode.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            compare_event <= 1'b0;
            period_event  <= 1'b0;
        end
        else
        begin
            period_event <= period_hit &
                            ~(compare_like & control_1.counter_clear_select_bit);
            if (control_1.mode_select_field == MODE_CAPTURE)
                compare_event <= capture_edge;
            else
                compare_event <= compare_hit &
                                 ~(compare_like & (compare_register == 10'h000));
        end
    end

    // Internal output level before polarity.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            raw_level <= 1'b0;
        else if (on_rise && control_1.mode_select_field != MODE_CAPTURE)
            raw_level <= control_1.output_control_bit;
        else if (control_1.mode_select_field == MODE_COMPARE && compare_hit &&
                 compare_register != 10'h000)
        begin
            unique case (control_1.function_select_field)
                2'b00: raw_level <= raw_level;
                2'b01: if (control_1.output_control_bit) raw_level <= 1'b0;
                2'b10: if (!control_1.output_control_bit) raw_level <= 1'b1;
                2'b11: raw_level <= ~raw_level;
            endcase
        end
        else if (control_1.mode_select_field == MODE_PWM)
        begin
            unique case (control_1.function_select_field)
                2'b00: raw_level <= ~control_1.output_control_bit;
                2'b01: raw_level <= control_1.output_control_bit;
                2'b10:
                begin
                    if (clear_hit)
                        raw_level <= control_1.output_control_bit;
                    else if (control_1.period_duty_swap_bit ? period_hit : compare_hit)
                        raw_level <= ~control_1.output_control_bit;
                end
                2'b11: if (compare_hit) raw_level <= ~control_1.output_control_bit;
            endcase
        end
    end

    // Pins leave flip-flops; the pair always moves together.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            timer_output_pin         <= 1'b0;
            complementary_output_pin <= 1'b1;
            timer_output_enable      <= 1'b0;
        end
        else
        begin
            timer_output_enable <= (control_1.mode_select_field != MODE_TIMER);
            timer_output_pin         <= raw_level ^ control_1.output_polarity_bit;
            complementary_output_pin <= ~(raw_level ^ control_1.output_polarity_bit);
        end
    end

endmodule

`default_nettype wire

// file: logic/standard_timer_params.svh
// Register offsets, reset values and timing counts for the standard timer.
`ifndef STANDARD_TIMER_PARAMS_SVH
`define STANDARD_TIMER_PARAMS_SVH

`define TIMER_CONTROL_0_OFFSET   12'h000
`define TIMER_CONTROL_1_OFFSET   12'h004
`define COUNTER_LOW_BYTE_OFFSET  12'h008
`define COUNTER_HIGH_BYTE_OFFSET 12'h00C
`define COMPARE_LOW_BYTE_OFFSET  12'h010
`define COMPARE_HIGH_BYTE_OFFSET 12'h014

`define TIMER_CONTROL_0_RESET    8'h00
`define TIMER_CONTROL_1_RESET    8'h00
`define COMPARE_RESET            10'h000

`define SYS_DIVIDE               2'h3
`define HIGH_DIVIDE_16           4'hF
`define HIGH_DIVIDE_64           6'h3F
`define PERIOD_STEP_SHIFT        7
`define FULL_SPAN                11'h400

`endif

// file: logic/standard_timer_pkg.sv
// Types shared by the standard timer and its bench.
package standard_timer_pkg;

    typedef enum logic [1:0] {
        MODE_COMPARE = 2'b00,
        MODE_CAPTURE = 2'b01,
        MODE_PWM     = 2'b10,
        MODE_TIMER   = 2'b11
    } mode_t;

    typedef enum logic [2:0] {
        CLK_SYS_4    = 3'b000,
        CLK_SYS      = 3'b001,
        CLK_HIGH_16  = 3'b010,
        CLK_HIGH_64  = 3'b011,
        CLK_TBC_A    = 3'b100,
        CLK_TBC_B    = 3'b101,
        CLK_EXT_RISE = 3'b110,
        CLK_EXT_FALL = 3'b111
    } clock_sel_t;

    typedef struct packed {
        logic       pause_bit;
        clock_sel_t clock_select_field;
        logic       on_off_bit;
        logic [2:0] period_value_field;
    } control_0_t;

    typedef struct packed {
        mode_t      mode_select_field;
        logic [1:0] function_select_field;
        logic       output_control_bit;
        logic       output_polarity_bit;
        logic       period_duty_swap_bit;
        logic       counter_clear_select_bit;
    } control_1_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } apb_rsp_t;

endpackage

// file: test/timer_pin_model.sv
// Model of the pins beside the timer: an external clock source and a capture signal.
`timescale 1ns/1ns
`default_nettype none

module timer_pin_model
(
    // Bench clock.
    input  wire logic clk,
    // Commands from the bench.
    input  wire logic ext_run,
    input  wire logic cap_level,
    // Pins towards the timer.
    output wire logic external_clock_pin,
    output wire logic capture_input_pin
);
    logic [1:0] phase = 2'h0;
    logic       cap_q = 1'b0;

    // The clock stands still unless the bench runs it; four cycles a period so
    // the timer's synchroniser sees every level.
    always_ff @(posedge clk)
    begin
        phase <= ext_run ? phase + 2'h1 : phase;
        cap_q <= cap_level;
    end

    assign external_clock_pin = phase[1];
    assign capture_input_pin  = cap_q;
endmodule

`default_nettype wire

// file: test/standard_timer_monitor.sv
// Checker of the standard timer ports, bound to the design.
`timescale 1ns/1ns
`default_nettype none

module standard_timer_monitor
(
    // Clock and reset.
    input  wire logic                         pclk,
    input  wire logic                         presetn,
    // Register bus.
    input  wire standard_timer_pkg::apb_req_t apb_req,
    input  wire standard_timer_pkg::apb_rsp_t apb_rsp,
    // Pins and events.
    input  wire logic                         capture_input_pin,
    input  wire logic                         timer_output_pin,
    input  wire logic                         timer_output_enable,
    input  wire logic                         complementary_output_pin,
    input  wire logic                         compare_event,
    input  wire logic                         period_event
);
    import standard_timer_pkg::*;

    control_0_t  c0;
    control_1_t  c1;
    logic [2:0]  quiet;
    logic [10:0] gap;
    logic        gap_ok;
    wire  logic  wr = apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite;
    wire  logic  calm = quiet[2];
    wire  logic [10:0] span = (c0.period_value_field == 3'h0) ? 11'h400 :
                              {1'b0, c0.period_value_field, 7'h00};

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Shadow of the control registers, so the checker knows the mode.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            c0 <= '0;
            c1 <= '0;
        end
        else if (wr && apb_req.paddr == 12'h000)
            c0 <= control_0_t'(apb_req.pwdata[7:0]);
        else if (wr && apb_req.paddr == 12'h004)
            c1 <= control_1_t'(apb_req.pwdata[7:0]);
    end

    // Quiet time since the last bus access and the gap between period events;
    // any access voids the gap, since it may have changed the setup.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            quiet <= 3'h0;
            gap <= 11'h000;
            gap_ok <= 1'b0;
        end
        else
        begin
            quiet <= apb_req.psel ? 3'h0 : (calm ? quiet : quiet + 3'h1);
            gap <= period_event ? 11'h001 : gap + 11'h001;
            gap_ok <= !apb_req.psel && (period_event || gap_ok);
        end
    end

    sequence setup_s;
        apb_req.psel && !apb_req.penable;
    endsequence

    sequence on_rise_s;
        wr && apb_req.paddr == 12'h000 && apb_req.pwdata[3] && !c0.on_off_bit &&
        c1.mode_select_field == MODE_COMPARE;
    endsequence

    sequence cap_edge_s;
        $rose(capture_input_pin) && calm && c0.on_off_bit &&
        c1.mode_select_field == MODE_CAPTURE && c1.function_select_field == 2'b00;
    endsequence

    AST_COMP_INV: assert property (complementary_output_pin == !timer_output_pin)
        else $error("complementary pin is not the inverse");
    AST_BUS_ANSWER: assert property (setup_s |=> apb_rsp.pready ##1 !apb_rsp.pready)
        else $error("bus answer not one cycle after setup");
    AST_CNT_WRITE: assert property (apb_req.psel && !apb_req.penable && apb_req.pwrite &&
        apb_req.paddr == 12'h008 |=> !apb_rsp.pslverr)
        else $error("counter write gave an error");
    AST_OUT_ENABLE: assert property (calm |->
        timer_output_enable == (c1.mode_select_field != MODE_TIMER))
        else $error("output enable wrong for mode");
    AST_PWM_FORCED: assert property (calm && c1.mode_select_field == MODE_PWM &&
        !c1.function_select_field[1] |-> timer_output_pin ==
        ((c1.function_select_field[0] ~^ c1.output_control_bit) ^ c1.output_polarity_bit))
        else $error("forced pwm level wrong");
    AST_CAP_EDGE: assert property (cap_edge_s |-> ##[2:6] compare_event)
        else $error("capture edge gave no event");
    AST_CAP_OFF: assert property (calm && c1.mode_select_field == MODE_CAPTURE &&
        c1.function_select_field == 2'b11 |-> !compare_event)
        else $error("event while capture disabled");
    AST_ON_RISE: assert property (on_rise_s |->
        ##[1:4] timer_output_pin == (c1.output_control_bit ^ c1.output_polarity_bit))
        else $error("output not set to initial level");
    AST_PERIOD_SPAN: assert property (period_event && gap_ok && !c0.pause_bit &&
        c0.clock_select_field == CLK_SYS && c1.mode_select_field != MODE_PWM |->
        gap == span)
        else $error("period event spacing wrong");
endmodule

bind standard_timer standard_timer_monitor i_mon
(
    .pclk                     (pclk),
    .presetn                  (presetn),
    .apb_req                  (apb_req),
    .apb_rsp                  (apb_rsp),
    .capture_input_pin        (capture_input_pin),
    .timer_output_pin         (timer_output_pin),
    .timer_output_enable      (timer_output_enable),
    .complementary_output_pin (complementary_output_pin),
    .compare_event            (compare_event),
    .period_event             (period_event)
);

`default_nettype wire

// file: test/standard_timer_tb.sv
// Self-checking bench for the standard timer.
`timescale 1ns/1ns
`default_nettype none

module standard_timer_tb;
    import standard_timer_pkg::*;

    logic        pclk;
    logic        presetn;
    apb_req_t    req;
    apb_rsp_t    rsp;
    logic        hs_strobe;
    logic        tb_strobe;
    logic        ext_run;
    logic        cap_level;
    logic        ext_pin;
    logic        cap_pin;
    logic        out_pin;
    logic        out_en;
    logic        out_n;
    logic        cmp_ev;
    logic        per_ev;
    logic        pol;
    logic [31:0] rd;
    logic [31:0] cv;
    logic [31:0] x;
    logic        err;
    int          failures;
    int          total_checks;
    int          cycles;
    int          g;
    int          div[8] = '{4, 1, 16, 64, 2, 2, 4, 4};
    int          ncap[4] = '{1, 1, 2, 0};

    standard_timer i_dut
    (
        .pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
        .high_speed_clock(hs_strobe), .time_base_clock(tb_strobe),
        .external_clock_pin(ext_pin), .capture_input_pin(cap_pin),
        .timer_output_pin(out_pin), .timer_output_enable(out_en),
        .complementary_output_pin(out_n), .compare_event(cmp_ev), .period_event(per_ev)
    );

    timer_pin_model i_pins
    (
        .clk(pclk), .ext_run(ext_run), .cap_level(cap_level),
        .external_clock_pin(ext_pin), .capture_input_pin(cap_pin)
    );

    // Clock of 20 ns.
    initial
    begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    // Time base strobe every other cycle; the timeout stops a hung run.
    always @(posedge pclk)
    begin
        tb_strobe <= ~tb_strobe;
        cycles <= cycles + 1;
        if (cycles == 60000)
        begin
            failures++;
            finish_test();
        end
    end

    // One bus transfer; waits for pready and releases after it.
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: {24'h0, d}};
        @(posedge pclk);
        req.penable <= 1'b1;
        do
            @(posedge pclk);
        while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req <= '0;
        @(posedge pclk);
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Counter read: high byte first so the low byte is latched with it.
    task automatic read_count();
        apb(1'b0, 12'h00C, 8'h00);
        cv = rd << 8;
        apb(1'b0, 12'h008, 8'h00);
        cv = cv | rd;
    endtask

    task automatic next_period(output int c);
        c = 0;
        do
        begin
            @(posedge pclk);
            c++;
        end
        while (per_ev !== 1'b1);
    endtask

    // Restart with the timer off first, then control 1, then control 0.
    task automatic restart(input logic [7:0] c1v, input logic [7:0] c0v);
        apb(1'b1, 12'h000, 8'h00);
        apb(1'b1, 12'h004, c1v);
        apb(1'b1, 12'h000, c0v);
    endtask

    task automatic finish_test();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        presetn = 1'b0;
        req = '0;
        hs_strobe = 1'b1;
        tb_strobe = 1'b0;
        ext_run = 1'b0;
        cap_level = 1'b0;
        failures = 0;
        total_checks = 0;
        cycles = 0;
        g = $urandom(39);
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, 12'h000, 8'h00);
        check(rd, 32'h0);
        apb(1'b0, 12'h004, 8'h00);
        check(rd, 32'h0);
        apb(1'b1, 12'h018, 8'hFF);
        check(err, 32'h1);
        $display("test reset and unmapped done");
        x = $urandom % 1024;
        apb(1'b1, 12'h010, x[7:0]);
        apb(1'b0, 12'h014, 8'h00);
        apb(1'b0, 12'h010, 8'h00);
        check(rd, 32'h0);
        apb(1'b1, 12'h010, x[7:0]);
        apb(1'b1, 12'h014, {6'h0, x[9:8]});
        apb(1'b0, 12'h014, 8'h00);
        check(rd, {30'h0, x[9:8]});
        apb(1'b0, 12'h010, 8'h00);
        check(rd, {24'h0, x[7:0]});
        $display("test compare buffer done");
        apb(1'b1, 12'h000, 8'h18);
        repeat (40) @(posedge pclk);
        apb(1'b1, 12'h000, 8'h98);
        read_count();
        x = cv;
        check(32'(x >= 40 && x <= 60), 32'h1);
        apb(1'b1, 12'h008, 8'h00);
        check(err, 32'h0);
        read_count();
        check(cv, x);
        apb(1'b1, 12'h000, 8'h18);
        repeat (100) @(posedge pclk);
        apb(1'b1, 12'h000, 8'h98);
        read_count();
        check(32'(cv - x >= 100 && cv - x <= 115), 32'h1);
        apb(1'b1, 12'h000, 8'h90);
        apb(1'b1, 12'h000, 8'h98);
        read_count();
        check(cv, 32'h0);
        $display("test counter done");
        for (int s = 0; s < 8; s++)
        begin
            ext_run <= (s >= 6);
            restart(8'h00, {1'b0, s[2:0], 1'b1, 3'h1});
            next_period(g);
            next_period(g);
            check(g, 128 * div[s]);
        end
        ext_run <= 1'b0;
        for (int n = 0; n < 8; n++)
        begin
            restart(8'h00, {4'h1, 1'b1, n[2:0]});
            next_period(g);
            next_period(g);
            check(g, (n == 0) ? 1024 : n * 128);
        end
        $display("test clocks and period done");
        apb(1'b1, 12'h010, 8'h40);
        apb(1'b1, 12'h014, 8'h00);
        for (int k = 0; k < 8; k++)
        begin
            pol = 1'($urandom);
            restart({2'b00, k[2:1], k[0], pol, 2'b00}, 8'h19);
            repeat (3) @(posedge pclk);
            check(out_pin, k[0] ^ pol);
            do
                @(posedge pclk);
            while (cmp_ev !== 1'b1);
            repeat (3) @(posedge pclk);
            x = (k[2:1] == 0) ? k[0] : (k[2:1] == 3) ? !k[0] : k[2];
            check(out_pin, x[0] ^ pol);
        end
        restart(8'hC0, 8'h19);
        repeat (3) @(posedge pclk);
        check(out_en, 32'h0);
        for (int k = 0; k < 4; k++)
        begin
            restart({3'b100, k[0], k[1], 3'b000}, 8'h19);
            repeat (3) @(posedge pclk);
            check(out_pin, k[0] ? k[1] : !k[1]);
        end
        $display("test output modes done");
        for (int f = 0; f < 4; f++)
        begin
            restart({2'b01, f[1:0], 4'h0}, 8'h18);
            g = 0;
            // Let the bus go quiet first, so the checker's capture assertions are armed.
            repeat (4) @(posedge pclk);
            cap_level <= 1'b1;
            repeat (20) @(posedge pclk) g += int'(cmp_ev);
            cap_level <= 1'b0;
            repeat (20) @(posedge pclk) g += int'(cmp_ev);
            check(g, ncap[f]);
        end
        $display("test capture done");
        finish_test();
    end
endmodule

`default_nettype wire
